// *** dts_pkg.sv ***
// constants, types and register map of the data trace sampler
package dts_pkg;
    // trace memory shape
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int BITS_N = 12;
    localparam int WORDS_N = 3;
    localparam int WORD_W = 16;
    localparam int ENTRY_W = BITS_N + WORDS_N * WORD_W;
    localparam int DLY_W = 8;
    localparam int EV_W = 3;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DLY = 8'h08;
    localparam logic [7:0] OFF_INTV = 8'h0c;
    localparam logic [7:0] OFF_SEL = 8'h10;
    localparam logic [7:0] OFF_IDX = 8'h14;
    localparam logic [7:0] OFF_RBITS = 8'h18;
    localparam logic [7:0] OFF_RW0 = 8'h1c;
    localparam logic [7:0] OFF_RW1 = 8'h20;
    localparam logic [7:0] OFF_RW2 = 8'h24;
    localparam logic [7:0] OFF_ISTAT = 8'h28;
    localparam logic [7:0] OFF_IEN = 8'h2c;
    localparam logic [7:0] OFF_ICLR = 8'h30;

    // control and select register fields
    localparam int CTRL_SAMP = 0;
    localparam int CTRL_TRACE = 1;
    localparam int CTRL_MODE = 2;
    localparam int SEL_WORDS = 16;

    // interrupt event positions
    localparam int EV_TRIG = 0;
    localparam int EV_DONE = 1;
    localparam int EV_DERR = 2;

    // values after reset
    localparam logic [DLY_W-1:0] DLY_RST = 8'h00;
    localparam logic [15:0] INTV_RST = 16'h000a;
    localparam logic [BITS_N-1:0] BMASK_RST = 12'hfff;
    localparam logic [WORDS_N-1:0] WMASK_RST = 3'h7;

    // interval timer unit of one microsecond
    localparam int CLK_NS = 25;
    localparam int UNIT_NS = 1000;
    localparam int UNIT_CYC = (UNIT_NS / CLK_NS) > 0 ? (UNIT_NS / CLK_NS) : 1;
    localparam int PRE_W = 6;

    typedef logic [PTR_W-1:0] dts_ptr_t;
    localparam dts_ptr_t LAST_PTR = dts_ptr_t'(DEPTH - 1);

    typedef enum logic [1:0] {
        DTS_IDLE = 2'b00,
        DTS_PRE = 2'b01,
        DTS_TRACE = 2'b10,
        DTS_DONE = 2'b11
    } dts_phase_e;
endpackage : dts_pkg

// *** dts_interval_timer.sv ***
// fixed interval tick generator for timer triggered sampling
`timescale 1ns/10ps
module dts_interval_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [15:0] interval,
    // one cycle tick
    output logic tick
);
    logic [dts_pkg::PRE_W-1:0] pre;
    logic [15:0] cnt;
    wire unit = (pre == dts_pkg::PRE_W'(dts_pkg::UNIT_CYC - 1));
    // zero interval behaves as one unit, never a stuck timer
    wire last = (cnt + 16'h0001 >= interval);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= '0;
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (!run) begin
            pre <= '0;
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick <= unit & last;
            pre <= unit ? '0 : pre + 1'b1;
            if (unit) begin
                cnt <= last ? 16'h0000 : cnt + 16'h0001;
            end
        end
    end
endmodule : dts_interval_timer

// *** dts_sampler.sv ***
// data trace sampler: capture, circular trace memory, apb registers
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
module dts_sampler (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program events from the cpu
    input wire logic marker_exec,
    input wire logic jump_skip,
    input wire logic end_exec,
    input wire logic marker_present,
    input wire logic prog_trace_start,
    // traced data
    input wire logic [dts_pkg::BITS_N-1:0] probe_bits,
    input wire logic [dts_pkg::WORD_W-1:0] probe_word0,
    input wire logic [dts_pkg::WORD_W-1:0] probe_word1,
    input wire logic [dts_pkg::WORD_W-1:0] probe_word2,
    // flags and interrupt
    output logic sampling_flag,
    output logic trace_start_flag,
    output logic tracing_flag,
    output logic complete_flag,
    output logic irq
);
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction : hit

    function automatic dts_pkg::dts_ptr_t ptr_inc(input dts_pkg::dts_ptr_t p);
        ptr_inc = (p == dts_pkg::LAST_PTR) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // software registers
    logic ctrl_samp;
    logic ctrl_trace;
    logic ctrl_mode;
    logic [dts_pkg::DLY_W-1:0] delay_r;
    logic [15:0] intv;
    logic [dts_pkg::BITS_N-1:0] bit_mask;
    logic [dts_pkg::WORDS_N-1:0] word_mask;
    dts_pkg::dts_ptr_t rd_idx;
    logic [dts_pkg::EV_W-1:0] int_stat;
    logic [dts_pkg::EV_W-1:0] int_en;

    // trace state
    dts_pkg::dts_phase_e phase;
    dts_pkg::dts_phase_e next_phase;
    dts_pkg::dts_ptr_t wr_ptr;
    dts_pkg::dts_ptr_t start_mark;
    dts_pkg::dts_ptr_t taken;
    logic [8:0] remain;
    logic ts_q;
    logic tick;
    logic [dts_pkg::ENTRY_W-1:0] mem [dts_pkg::DEPTH];

    // apb decode
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite;
    wire w_ctrl = wr & hit(paddr, dts_pkg::OFF_CTRL);
    wire w_dly = wr & hit(paddr, dts_pkg::OFF_DLY);
    wire w_intv = wr & hit(paddr, dts_pkg::OFF_INTV);
    wire w_sel = wr & hit(paddr, dts_pkg::OFF_SEL);
    wire w_idx = wr & hit(paddr, dts_pkg::OFF_IDX);
    wire w_ien = wr & hit(paddr, dts_pkg::OFF_IEN);
    wire w_iclr = wr & hit(paddr, dts_pkg::OFF_ICLR);
    wire mapped = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'b00)
        && (paddr[7:0] <= dts_pkg::OFF_ICLR);

    // sample capture with per-bit and per-word selection
    logic [dts_pkg::WORD_W-1:0] pw [dts_pkg::WORDS_N];
    logic [dts_pkg::ENTRY_W-1:0] entry;
    assign pw[0] = probe_word0;
    assign pw[1] = probe_word1;
    assign pw[2] = probe_word2;
    assign entry[dts_pkg::BITS_N-1:0] = probe_bits & bit_mask;
    genvar g;
    generate
        for (g = 0; g < dts_pkg::WORDS_N; g++) begin : g_word
            assign entry[dts_pkg::BITS_N + g*dts_pkg::WORD_W +: dts_pkg::WORD_W] =
                word_mask[g] ? pw[g] : '0;
        end
    endgenerate

    // sample triggers
    wire recording = (phase == dts_pkg::DTS_PRE) || (phase == dts_pkg::DTS_TRACE);
    wire prog_marker = marker_exec & ~jump_skip;
    wire prog_end = end_exec & ~marker_present;
    wire prog_src = marker_present ? prog_marker : prog_end;
    wire fire = recording & (ctrl_mode ? tick : prog_src);

    dts_interval_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(recording & ctrl_mode),
        .interval(intv),
        .tick(tick)
    );

    // trace start from software or from the program
    wire ts = ctrl_trace | prog_trace_start;
    wire trig = ts & ~ts_q & (phase == dts_pkg::DTS_PRE);

    // signed delay placement of the start marker
    wire dneg = delay_r[dts_pkg::DLY_W-1];
    wire [7:0] dmag = dneg ? 8'h00 - delay_r : delay_r;
    // too deep a negative delay is clipped to the history held
    wire neg_over = dneg && (dmag > {4'h0, taken});
    wire [3:0] neg_eff = neg_over ? taken : dmag[3:0];
    wire [3:0] mark_init = dneg ? wr_ptr - neg_eff : wr_ptr + dmag[3:0];
    wire [8:0] rem_init = dneg ? 9'(dts_pkg::DEPTH) - {5'h00, neg_eff}
        : 9'(dts_pkg::DEPTH) + {1'b0, dmag};
    wire [8:0] rem_base = (phase == dts_pkg::DTS_PRE) ? rem_init : remain;
    wire tracing_now = trig || (phase == dts_pkg::DTS_TRACE);
    wire done_now = fire && tracing_now && (rem_base == 9'h001);

    always_comb begin
        next_phase = phase;
        case (phase)
            dts_pkg::DTS_IDLE: begin
                if (ctrl_samp) next_phase = dts_pkg::DTS_PRE;
            end
            dts_pkg::DTS_PRE: begin
                if (!ctrl_samp) next_phase = dts_pkg::DTS_IDLE;
                else if (trig) next_phase = done_now ? dts_pkg::DTS_DONE : dts_pkg::DTS_TRACE;
            end
            dts_pkg::DTS_TRACE: begin
                if (!ctrl_samp) next_phase = dts_pkg::DTS_IDLE;
                else if (done_now) next_phase = dts_pkg::DTS_DONE;
            end
            dts_pkg::DTS_DONE: begin
                if (!ctrl_samp) next_phase = dts_pkg::DTS_IDLE;
            end
            default: next_phase = dts_pkg::DTS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= dts_pkg::DTS_IDLE;
            ts_q <= 1'b0;
        end else begin
            phase <= next_phase;
            ts_q <= ts;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            taken <= '0;
        end else if (phase == dts_pkg::DTS_IDLE) begin
            wr_ptr <= '0;
            taken <= '0;
        end else if (fire) begin
            wr_ptr <= ptr_inc(wr_ptr);
            if (taken != dts_pkg::LAST_PTR) taken <= taken + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_mark <= '0;
            remain <= 9'h000;
        end else begin
            if (trig) start_mark <= mark_init;
            if (tracing_now) remain <= rem_base - {8'h00, fire};
        end
    end

    // storage needs no reset; readback before any write is undefined
    always_ff @(posedge pclk) begin
        if (fire) mem[wr_ptr] <= entry;
    end

    // register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_samp <= 1'b0;
            ctrl_trace <= 1'b0;
            ctrl_mode <= 1'b0;
            delay_r <= dts_pkg::DLY_RST;
            intv <= dts_pkg::INTV_RST;
            bit_mask <= dts_pkg::BMASK_RST;
            word_mask <= dts_pkg::WMASK_RST;
            rd_idx <= '0;
            int_en <= '0;
        end else begin
            if (w_ctrl) begin
                ctrl_samp <= pwdata[dts_pkg::CTRL_SAMP];
                ctrl_trace <= pwdata[dts_pkg::CTRL_TRACE];
                ctrl_mode <= pwdata[dts_pkg::CTRL_MODE];
            end
            if (w_dly) delay_r <= pwdata[dts_pkg::DLY_W-1:0];
            if (w_intv) intv <= pwdata[15:0];
            if (w_sel) begin
                bit_mask <= pwdata[dts_pkg::BITS_N-1:0];
                word_mask <= pwdata[dts_pkg::SEL_WORDS +: dts_pkg::WORDS_N];
            end
            if (w_idx) rd_idx <= pwdata[dts_pkg::PTR_W-1:0];
            if (w_ien) int_en <= pwdata[dts_pkg::EV_W-1:0];
        end
    end

    // sticky events: a new event wins over a clear in the same cycle
    logic [dts_pkg::EV_W-1:0] ev;
    assign ev[dts_pkg::EV_TRIG] = trig;
    assign ev[dts_pkg::EV_DONE] = (next_phase == dts_pkg::DTS_DONE) && (phase != dts_pkg::DTS_DONE);
    assign ev[dts_pkg::EV_DERR] = trig & neg_over;
    wire [dts_pkg::EV_W-1:0] clr = w_iclr ? pwdata[dts_pkg::EV_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) int_stat <= '0;
        else int_stat <= (int_stat & ~clr) | ev;
    end

    // read mux
    wire [dts_pkg::ENTRY_W-1:0] rd_ent = mem[rd_idx];
    wire [31:0] ctrl_word = {29'h0, ctrl_mode, ctrl_trace, ctrl_samp};
    wire [31:0] stat_word = {4'h0, taken, 4'h0, wr_ptr, 4'h0, start_mark,
        4'h0, ts, ctrl_samp, tracing_flag, complete_flag};
    wire [31:0] rd_word =
        hit(paddr, dts_pkg::OFF_CTRL) ? ctrl_word :
        hit(paddr, dts_pkg::OFF_STAT) ? stat_word :
        hit(paddr, dts_pkg::OFF_DLY) ? {24'h0, delay_r} :
        hit(paddr, dts_pkg::OFF_INTV) ? {16'h0, intv} :
        hit(paddr, dts_pkg::OFF_SEL) ? {13'h0, word_mask, 4'h0, bit_mask} :
        hit(paddr, dts_pkg::OFF_IDX) ? {28'h0, rd_idx} :
        hit(paddr, dts_pkg::OFF_RBITS) ? {20'h0, rd_ent[11:0]} :
        hit(paddr, dts_pkg::OFF_RW0) ? {16'h0, rd_ent[27:12]} :
        hit(paddr, dts_pkg::OFF_RW1) ? {16'h0, rd_ent[43:28]} :
        hit(paddr, dts_pkg::OFF_RW2) ? {16'h0, rd_ent[59:44]} :
        hit(paddr, dts_pkg::OFF_ISTAT) ? {29'h0, int_stat} :
        hit(paddr, dts_pkg::OFF_IEN) ? {29'h0, int_en} : 32'h0;

    // data is latched in setup so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0 : rd_word;
            pslverr <= ~mapped;
        end
    end

    assign pready = psel & penable;
    assign sampling_flag = ctrl_samp;
    assign trace_start_flag = ts;
    assign tracing_flag = (phase == dts_pkg::DTS_TRACE);
    assign complete_flag = (phase == dts_pkg::DTS_DONE);
    assign irq = |(int_stat & int_en);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_trig_open;
        trig && !fire && ctrl_samp;
    endsequence

    sequence s_last_write;
        fire && tracing_now && rem_base == 9'h001 && ctrl_samp;
    endsequence

    a_capture_bits: assert property (
        fire |=> mem[$past(wr_ptr)][11:0] == ($past(probe_bits) & $past(bit_mask)))
        else $error("captured bits differ from masked probe bits");

    // pointers clear one edge after the phase has returned to idle
    a_idle_quiet: assert property (
        !ctrl_samp |=> (phase == dts_pkg::DTS_IDLE && !fire) ##1 (wr_ptr == '0 && taken == '0))
        else $error("sampling continued without the start bit");

    a_trace_store: assert property (
        fire |=> mem[$past(wr_ptr)] == $past(entry))
        else $error("sample not stored at the write pointer");

    a_marker_sample: assert property (
        !ctrl_mode && marker_present && marker_exec && !jump_skip && recording
        |=> wr_ptr == ptr_inc($past(wr_ptr)))
        else $error("executed marker took no sample");

    a_end_sample: assert property (
        !ctrl_mode && !marker_present && end_exec && recording
        |=> wr_ptr == ptr_inc($past(wr_ptr)))
        else $error("program end took no sample");

    a_timer_sample: assert property (
        ctrl_mode && tick && recording |=> wr_ptr == ptr_inc($past(wr_ptr)))
        else $error("timer tick took no sample");

    a_tracing_flag: assert property (
        s_trig_open |=> tracing_flag && !complete_flag)
        else $error("tracing flag not raised by the trigger");

    a_trace_done: assert property (
        s_last_write |=> complete_flag && !tracing_flag && wr_ptr == start_mark)
        else $error("trace did not complete at the start marker");

    a_jump_skip: assert property (
        !ctrl_mode && marker_present && jump_skip && recording |=> wr_ptr == $past(wr_ptr))
        else $error("skipped marker took a sample");

    a_delay_mark: assert property (
        trig && !dneg |=> start_mark == 4'($past(wr_ptr) + $past(delay_r[3:0])))
        else $error("start marker misplaced for positive delay");

    a_wrap_ptr: assert property (
        fire && wr_ptr == dts_pkg::LAST_PTR |=> wr_ptr == '0)
        else $error("write pointer did not wrap to the first location");

    a_neg_mark: assert property (
        trig && delay_r[7] && ((8'h00 - delay_r) <= {4'h0, taken})
        |=> start_mark == 4'($past(wr_ptr) + $past(delay_r[3:0])))
        else $error("start marker misplaced for negative delay");

    a_clip_event: assert property (
        trig && delay_r[7] && ((8'h00 - delay_r) > {4'h0, taken})
        |=> int_stat[dts_pkg::EV_DERR] && start_mark == 4'($past(wr_ptr) - $past(taken)))
        else $error("deep negative delay not clipped to the samples held");

    a_tracing_hold: assert property (
        tracing_flag && ctrl_samp && !(fire && remain == 9'h001) |=> tracing_flag)
        else $error("tracing flag dropped before the trace completed");

    a_done_frozen: assert property (
        complete_flag && ctrl_samp |=> complete_flag && wr_ptr == $past(wr_ptr))
        else $error("trace memory written after completion");

    a_sample_gate: assert property (
        fire |-> $past(ctrl_samp))
        else $error("sample taken before the start bit was set");

    a_end_ignored: assert property (
        !ctrl_mode && marker_present && end_exec && !marker_exec && recording |=> wr_ptr == $past(wr_ptr))
        else $error("program end sampled although markers are present");
endmodule : dts_sampler

// *** dts_apb_host.sv ***
// apb master model standing in for the programming tool
`timescale 1ns/10ps
module dts_apb_host (
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int stalls;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        stalls = 0;
    end
    // only this host ever writes the control register
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count is assumed; only the bench watchdog ends a hung wait
        do begin
            @(posedge pclk);
            if (pready !== 1'b1) stalls++;
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show a changed value, not the last one
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : dts_apb_host

// *** dts_tb.sv ***
// self-checking testbench of the data trace sampler
`timescale 1ns/10ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd_q;
    logic rd_e, marker_exec, jump_skip, end_exec, marker_present, prog_trace_start;
    logic [dts_pkg::BITS_N-1:0] probe_bits;
    logic [dts_pkg::WORD_W-1:0] probe_word0, probe_word1, probe_word2;
    logic sampling_flag, trace_start_flag, tracing_flag, complete_flag, irq;
    int miscompares, checked;

    dts_sampler u_dts_sampler (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .marker_exec(marker_exec), .jump_skip(jump_skip), .end_exec(end_exec),
        .marker_present(marker_present), .prog_trace_start(prog_trace_start),
        .probe_bits(probe_bits), .probe_word0(probe_word0), .probe_word1(probe_word1),
        .probe_word2(probe_word2), .sampling_flag(sampling_flag), .trace_start_flag(trace_start_flag),
        .tracing_flag(tracing_flag), .complete_flag(complete_flag), .irq(irq));
    dts_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, {24'h0, a}, d, rd_q, rd_e);
        #1;
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, {24'h0, a}, 32'h0, rd_q, rd_e);
        #1;
        check(what, rd_q, exp);
    endtask : rchk
    // status word and flag pins together: wptr, then trace start..complete nibble
    task automatic st(input logic [3:0] wp, input logic [3:0] fl);
        host.xfer(1'b0, {24'h0, dts_pkg::OFF_STAT}, 32'h0, rd_q, rd_e);
        #1;
        check("stat", {24'h0, rd_q[19:16], rd_q[3:0]}, {24'h0, wp, fl});
        check("flag pins", {28'h0, trace_start_flag, sampling_flag, tracing_flag, complete_flag}, {28'h0, fl});
    endtask : st
    task automatic fire(input logic mk, input logic skip, input int n);
        repeat (n) begin
            @(posedge pclk);
            marker_exec <= mk;
            end_exec <= ~mk;
            jump_skip <= skip;
            @(posedge pclk);
            marker_exec <= 1'b0;
            end_exec <= 1'b0;
            jump_skip <= 1'b0;
        end
        #1;
    endtask : fire

    task automatic t_reset;
        rchk("delay", dts_pkg::OFF_DLY, 32'h0);
        rchk("interval", dts_pkg::OFF_INTV, 32'h0000000a);
        rchk("select", dts_pkg::OFF_SEL, 32'h00070fff);
        check("mapped err", {31'h0, rd_e}, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        check("unmapped err", {31'h0, rd_e}, 32'h1);
        st(4'h0, 4'h0);
    endtask : t_reset
    task automatic t_marker;
        @(posedge pclk);
        marker_present <= 1'b1;
        probe_bits <= 12'habc;
        probe_word0 <= 16'h1234;
        probe_word1 <= 16'h5678;
        probe_word2 <= 16'h9abc;
        fire(1'b1, 1'b0, 1);
        st(4'h0, 4'h0);
        wr(dts_pkg::OFF_SEL, 32'h000500f0);
        wr(dts_pkg::OFF_CTRL, 32'h1);
        fire(1'b1, 1'b0, 1);
        fire(1'b1, 1'b1, 1);
        st(4'h1, 4'h4);
        fire(1'b1, 1'b0, 2);
        fire(1'b0, 1'b0, 1);
        st(4'h3, 4'h4);
        wr(dts_pkg::OFF_IDX, 32'h0);
        rchk("bits", dts_pkg::OFF_RBITS, 32'h0b0);
        rchk("word0", dts_pkg::OFF_RW0, 32'h1234);
        rchk("word1", dts_pkg::OFF_RW1, 32'h0);
        rchk("word2", dts_pkg::OFF_RW2, 32'h9abc);
    endtask : t_marker
    task automatic t_negdelay;
        // three samples held, so two back is allowed
        wr(dts_pkg::OFF_DLY, 32'h000000fe);
        wr(dts_pkg::OFF_CTRL, 32'h3);
        st(4'h3, 4'he);
        check("mark", {28'h0, rd_q[11:8]}, 32'h1);
        fire(1'b1, 1'b0, 13);
        st(4'h0, 4'he);
        fire(1'b1, 1'b0, 1);
        st(4'h1, 4'hd);
        check("mark at end", {28'h0, rd_q[11:8]}, 32'h1);
        fire(1'b1, 1'b0, 1);
        st(4'h1, 4'hd);
        rchk("istat", dts_pkg::OFF_ISTAT, 32'h3);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(dts_pkg::OFF_IEN, 32'h2);
        check("irq on", {31'h0, irq}, 32'h1);
        wr(dts_pkg::OFF_ICLR, 32'h2);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rchk("istat left", dts_pkg::OFF_ISTAT, 32'h1);
    endtask : t_negdelay
    task automatic t_enddelay;
        wr(dts_pkg::OFF_CTRL, 32'h0);
        wr(dts_pkg::OFF_ICLR, 32'h7);
        @(posedge pclk);
        marker_present <= 1'b0;
        wr(dts_pkg::OFF_DLY, 32'h1);
        wr(dts_pkg::OFF_CTRL, 32'h1);
        fire(1'b1, 1'b0, 1);
        fire(1'b0, 1'b0, 2);
        st(4'h2, 4'h4);
        @(posedge pclk);
        prog_trace_start <= 1'b1;
        st(4'h2, 4'he);
        check("mark", {28'h0, rd_q[11:8]}, 32'h3);
        fire(1'b0, 1'b0, 16);
        st(4'h2, 4'he);
        fire(1'b0, 1'b0, 1);
        st(4'h3, 4'hd);
        rchk("istat", dts_pkg::OFF_ISTAT, 32'h3);
        @(posedge pclk);
        prog_trace_start <= 1'b0;
    endtask : t_enddelay
    task automatic t_clip;
        wr(dts_pkg::OFF_CTRL, 32'h0);
        wr(dts_pkg::OFF_ICLR, 32'h7);
        wr(dts_pkg::OFF_DLY, 32'h000000fb);
        wr(dts_pkg::OFF_CTRL, 32'h1);
        fire(1'b0, 1'b0, 1);
        wr(dts_pkg::OFF_CTRL, 32'h3);
        rchk("clip istat", dts_pkg::OFF_ISTAT, 32'h5);
    endtask : t_clip
    task automatic t_timer;
        wr(dts_pkg::OFF_CTRL, 32'h0);
        wr(dts_pkg::OFF_INTV, 32'h1);
        wr(dts_pkg::OFF_CTRL, 32'h5);
        // one tick every forty cycles at one microsecond
        repeat (30) @(posedge pclk);
        st(4'h0, 4'h4);
        repeat (20) @(posedge pclk);
        st(4'h1, 4'h4);
        repeat (30) @(posedge pclk);
        st(4'h2, 4'h4);
    endtask : t_timer

    task automatic conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        conclude();
    end
    initial begin
        miscompares = 0;
        checked = 0;
        presetn = 1'b0;
        {marker_exec, jump_skip, end_exec, marker_present, prog_trace_start} = 5'h0;
        probe_bits = 12'h0;
        probe_word0 = 16'h0;
        probe_word1 = 16'h0;
        probe_word2 = 16'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_marker();
        t_negdelay();
        t_enddelay();
        t_clip();
        t_timer();
        check("apb stalls", host.stalls, 32'h0);
        conclude();
    end
endmodule : tb
